// ---- rtl/reset_power_pkg.sv ----
// Constants shared by the reset and power sequencer.
// Assumes a single 25 MHz system clock standing in for the oscillator clock.
package reset_power_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 40;
	localparam int XTAL_BASE_CYC     = 1024;
	localparam int XTAL_EXTRA_MIN_NS = 60000;
	localparam int XTAL_EXTRA_CYC    =
		(XTAL_EXTRA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XTAL_WAKE_CYC     = XTAL_BASE_CYC + XTAL_EXTRA_CYC;
	localparam int RC_WAKE_MIN_NS    = 200000;
	localparam int RC_WAKE_CYC       =
		(RC_WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_WAKE_CYC      = 32;
	localparam int WAKE_CNT_W        = 13;

	// ---------------------------------------------------------------
	// Clock divider
	// ---------------------------------------------------------------
	localparam int DIV_W     = 8;
	localparam int DIV_CNT_W = 9;

	// ---------------------------------------------------------------
	// Clock source selection
	// ---------------------------------------------------------------
	localparam logic [1:0] SRC_CRYSTAL = 2'h0;
	localparam logic [1:0] SRC_RC      = 2'h1;
	localparam logic [1:0] SRC_WDOSC   = 2'h2;
	localparam logic [1:0] SRC_EXT     = 2'h3;

	// ---------------------------------------------------------------
	// Reset cause register layout
	// ---------------------------------------------------------------
	localparam int CAUSE_W   = 6;
	localparam int CAUSE_EXT = 0;
	localparam int CAUSE_SW  = 1;
	localparam int CAUSE_WD  = 2;
	localparam int CAUSE_BRK = 3;
	localparam int CAUSE_POF = 4;
	localparam int CAUSE_BOF = 5;
	localparam logic [5:0] CAUSE_POWER_ON = 6'h30;

	// ---------------------------------------------------------------
	// Boot address
	// ---------------------------------------------------------------
	localparam logic [7:0]  BOOT_LOW_BYTE = 8'h00;
	localparam logic [15:0] RESET_VECTOR  = 16'h0000;

	// ---------------------------------------------------------------
	// Power modes
	// ---------------------------------------------------------------
	localparam logic [1:0] REQ_IDLE       = 2'h1;
	localparam logic [1:0] REQ_POWER_DOWN = 2'h2;
	localparam logic [1:0] REQ_TOTAL_PD   = 2'h3;

	typedef enum logic [2:0] {
		ST_RUN  = 3'h0,
		ST_IDLE = 3'h1,
		ST_PD   = 3'h2,
		ST_TPD  = 3'h3,
		ST_WAKE = 3'h4
	} power_state_t;

endpackage

// ---- rtl/reset_power_sequencer.sv ----
// Reset, clock wake-up, clock divide and power-mode control for a small
// microcontroller. Supply monitors deliver one comparator level per trip
// point; reset sources and firmware strobes are synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Crystal wake delay: 1024 cycles plus 60us.
// - RC oscillator wake delay at least 200us.
// - Watchdog or external clock: 32 cycles.
// - Core clock divided, ratio up to 510.
// - Divider rewrite applied without stopping execution.
// - Low-power select bit cleared on every reset.
// - Brownout reset always on except total power-down.
// - Four trip levels each, separate selects.
// - Flash protect at 2.4V, off in power-down.
// - Brownout follows supply below selected level.
// - Power-on flag set at power-up, software clears.
// - Idle keeps peripherals, exits on interrupt/reset.
// - Power-down stops oscillator, wakes on reset/interrupt.
// - Monitors run in power-down; RC conditionally.
// - Total power-down also stops brownout, comparators.
// - Shared pin is reset when enable bit set.
// - Pin always reset during power-up.
// - Each reset source has flag; write zero clears.
// - Power-on or watchdog: set POWER_ON_FLAG, BROWNOUT_FLAG only.
// - Other resets keep existing flags.
// - Boot address is vector byte then zero.
// - Boot address on break, status bit, forced programming.
module reset_power_sequencer #(
	parameter int RC_WAKE_CYCLES = reset_power_pkg::RC_WAKE_CYC
) (
	input  wire logic        clk_sys,                 // Oscillator clock.
	input  wire logic        rst_b,                   // Power-on reset, low.
	input  wire logic [1:0]  clockSourceSel,          // Oscillator source.
	input  wire logic [7:0]  clock_divider_value,     // Divide-by-2M value.
	input  wire logic        lowPowerWrite,           // Strobe for select.
	input  wire logic        lowPowerData,            // Value to write.
	input  wire logic [1:0]  modeRequest,             // Requested mode.
	input  wire logic        modeEnter,               // Mode entry strobe.
	input  wire logic        idleWakeInt,             // Enabled interrupt.
	input  wire logic        powerDownWakeInt,        // Wake-capable int.
	input  wire logic        rtcEnable,               // Real-time timer on.
	input  wire logic        brownout_reset_trip_sel_hi, // Reset trip hi.
	input  wire logic        brownout_reset_trip_sel_lo, // Reset trip lo.
	input  wire logic        brownout_int_trip_sel_hi,   // Int trip hi.
	input  wire logic        brownout_int_trip_sel_lo,   // Int trip lo.
	input  wire logic        brownoutIntEnable,       // Interrupt enable.
	input  wire logic [3:0]  supplyAboveTrip,         // Per trip level.
	input  wire logic        supplyAboveFlashTrip,    // Above 2.4 V.
	input  wire logic        powerOnDetect,           // Analog power-on.
	input  wire logic        shared_reset_pin,        // Pin level.
	input  wire logic        reset_pin_enable,        // Pin as reset.
	input  wire logic        watchdogReset,           // Watchdog pulse.
	input  wire logic        softwareReset,           // Software pulse.
	input  wire logic        uartBreakReset,          // Break detect pulse.
	input  wire logic        causeWrite,              // Cause write strobe.
	input  wire logic [5:0]  causeWriteData,          // Zero bits clear.
	input  wire logic [7:0]  bootVector,              // Boot vector byte.
	input  wire logic        bootStatusBit,           // Boot status bit 0.
	input  wire logic        in_system_programming,   // Forced at power-on.
	output logic             cpuCoreClockTick,        // Core clock enable.
	output logic             coreClockRun,            // Core clock released.
	output logic             peripheralClockRun,      // Peripherals clocked.
	output logic             oscillatorRun,           // Oscillator running.
	output logic             rcOscRun,                // RC oscillator on.
	output logic             brownoutDetectOn,        // Detectors powered.
	output logic             comparatorsOn,           // Comparators powered.
	output logic             chipReset,               // Core reset.
	output logic             brownoutIntReq,          // Brownout interrupt.
	output logic             flashProgramBlock,       // Flash write blocked.
	output logic             sharedPinInput,          // Pin as plain input.
	output logic             low_power_clock_select,  // Low-power select.
	output logic [5:0]       reset_cause_reg,         // Reset cause flags.
	output logic [15:0]      bootAddress              // Fetch start.
);

	// ---------------------------------------------------------------
	// Reset sources
	// ---------------------------------------------------------------
	logic       powerUpPhase;
	logic [1:0] resetTripSel;
	logic [1:0] intTripSel;
	logic       brownoutCond;
	logic       pinReset;
	logic       powerOnEvent;
	logic       anyReset;

	assign resetTripSel = {brownout_reset_trip_sel_hi,
		brownout_reset_trip_sel_lo};
	assign intTripSel   = {brownout_int_trip_sel_hi,
		brownout_int_trip_sel_lo};
	assign brownoutCond = brownoutDetectOn
		&& !supplyAboveTrip[resetTripSel];
	assign pinReset     = !shared_reset_pin
		&& (reset_pin_enable || powerUpPhase);
	assign powerOnEvent = powerOnDetect || watchdogReset;
	assign anyReset     = pinReset || powerOnEvent || brownoutCond
		|| softwareReset || uartBreakReset;

	// ---------------------------------------------------------------
	// Power mode and wake-up sequencing
	// ---------------------------------------------------------------
	reset_power_pkg::power_state_t state;
	reset_power_pkg::power_state_t next_state;
	logic [reset_power_pkg::WAKE_CNT_W-1:0] wakeCount;
	logic [reset_power_pkg::WAKE_CNT_W-1:0] next_wakeCount;
	logic [reset_power_pkg::WAKE_CNT_W-1:0] wakeTarget;
	logic next_powerUpPhase;

	always_comb
	begin
		unique case (clockSourceSel)
			reset_power_pkg::SRC_CRYSTAL:
				wakeTarget = reset_power_pkg::WAKE_CNT_W'(
					reset_power_pkg::XTAL_WAKE_CYC);
			reset_power_pkg::SRC_RC:
				wakeTarget = reset_power_pkg::WAKE_CNT_W'(
					RC_WAKE_CYCLES);
			reset_power_pkg::SRC_WDOSC,
			reset_power_pkg::SRC_EXT:
				wakeTarget = reset_power_pkg::WAKE_CNT_W'(
					reset_power_pkg::EXT_WAKE_CYC);
		endcase
	end

	always_comb
	begin
		next_state        = state;
		next_wakeCount    = '0;
		next_powerUpPhase = powerUpPhase;
		if (anyReset || chipReset)
		begin
			next_state = reset_power_pkg::ST_WAKE;
			if (powerOnDetect)
			begin
				next_powerUpPhase = 1'b1;
			end
		end
		else
		begin
			unique case (state)
				reset_power_pkg::ST_RUN:
				begin
					if (modeEnter)
					begin
						unique case (modeRequest)
							reset_power_pkg::REQ_IDLE:
								next_state = reset_power_pkg::ST_IDLE;
							reset_power_pkg::REQ_POWER_DOWN:
								next_state = reset_power_pkg::ST_PD;
							reset_power_pkg::REQ_TOTAL_PD:
								next_state = reset_power_pkg::ST_TPD;
							default:
								next_state = reset_power_pkg::ST_RUN;
						endcase
					end
				end
				reset_power_pkg::ST_IDLE:
				begin
					if (idleWakeInt)
					begin
						next_state = reset_power_pkg::ST_RUN;
					end
				end
				reset_power_pkg::ST_PD,
				reset_power_pkg::ST_TPD:
				begin
					if (powerDownWakeInt)
					begin
						next_state = reset_power_pkg::ST_WAKE;
					end
				end
				reset_power_pkg::ST_WAKE:
				begin
					next_wakeCount = wakeCount + 1'b1;
					if (wakeCount >= wakeTarget - 1'b1)
					begin
						next_state        = reset_power_pkg::ST_RUN;
						next_wakeCount    = '0;
						next_powerUpPhase = 1'b0;
					end
				end
				default:
					next_state = reset_power_pkg::ST_WAKE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state        <= reset_power_pkg::ST_WAKE;
			wakeCount    <= '0;
			powerUpPhase <= 1'b1;
		end
		else
		begin
			state        <= next_state;
			wakeCount    <= next_wakeCount;
			powerUpPhase <= next_powerUpPhase;
		end
	end

	// ---------------------------------------------------------------
	// Clock divider, flags and status outputs
	// ---------------------------------------------------------------
	logic [reset_power_pkg::DIV_CNT_W-1:0] divCount;
	logic [reset_power_pkg::DIV_CNT_W-1:0] next_divCount;
	logic [reset_power_pkg::DIV_CNT_W-1:0] divLimit;
	logic       pdState;
	logic       next_tick;
	logic [5:0] next_cause;
	logic [5:0] causeSet;
	logic       bootPending;
	logic       next_bootPending;
	logic       next_lowPower;
	logic [15:0] next_bootAddress;

	assign divLimit = {clock_divider_value, 1'b0};
	assign pdState  = (next_state == reset_power_pkg::ST_PD)
		|| (next_state == reset_power_pkg::ST_TPD);

	always_comb
	begin
		next_tick     = 1'b0;
		next_divCount = '0;
		if (next_state == reset_power_pkg::ST_RUN)
		begin
			// A shrunken ratio wraps at once, so no tick is ever lost.
			if (clock_divider_value == '0)
			begin
				next_tick = 1'b1;
			end
			else if (divCount >= divLimit - 1'b1)
			begin
				next_tick = 1'b1;
			end
			else
			begin
				next_divCount = divCount + 1'b1;
			end
		end

		causeSet = '0;
		causeSet[reset_power_pkg::CAUSE_EXT] = pinReset;
		causeSet[reset_power_pkg::CAUSE_SW]  = softwareReset;
		causeSet[reset_power_pkg::CAUSE_BRK] = uartBreakReset;
		causeSet[reset_power_pkg::CAUSE_BOF] = brownoutCond;
		next_cause = reset_cause_reg;
		if (causeWrite)
		begin
			next_cause = next_cause & causeWriteData;
		end
		next_cause = next_cause | causeSet;
		if (powerOnEvent)
		begin
			next_cause = reset_power_pkg::CAUSE_POWER_ON;
		end

		next_lowPower = low_power_clock_select;
		if (anyReset)
		begin
			next_lowPower = 1'b0;
		end
		else if (lowPowerWrite)
		begin
			next_lowPower = lowPowerData;
		end

		next_bootPending = bootPending || uartBreakReset;
		next_bootAddress = bootAddress;
		if (chipReset && !anyReset)
		begin
			next_bootPending = 1'b0;
			if (bootPending || bootStatusBit
				|| (powerUpPhase && in_system_programming))
			begin
				next_bootAddress = {bootVector,
					reset_power_pkg::BOOT_LOW_BYTE};
			end
			else
			begin
				next_bootAddress = reset_power_pkg::RESET_VECTOR;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divCount               <= '0;
			cpuCoreClockTick       <= 1'b0;
			coreClockRun           <= 1'b0;
			peripheralClockRun     <= 1'b0;
			oscillatorRun          <= 1'b1;
			rcOscRun               <= 1'b0;
			brownoutDetectOn       <= 1'b1;
			comparatorsOn          <= 1'b1;
			chipReset              <= 1'b1;
			brownoutIntReq         <= 1'b0;
			flashProgramBlock      <= 1'b0;
			sharedPinInput         <= 1'b0;
			low_power_clock_select <= 1'b0;
			reset_cause_reg        <= reset_power_pkg::CAUSE_POWER_ON;
			bootPending            <= 1'b0;
			bootAddress            <= reset_power_pkg::RESET_VECTOR;
		end
		else
		begin
			divCount           <= next_divCount;
			cpuCoreClockTick   <= next_tick;
			coreClockRun       <= next_state == reset_power_pkg::ST_RUN;
			peripheralClockRun <= (next_state == reset_power_pkg::ST_RUN)
				|| (next_state == reset_power_pkg::ST_IDLE);
			oscillatorRun      <= !pdState;
			rcOscRun           <= (clockSourceSel == reset_power_pkg::SRC_RC)
				&& (!pdState || rtcEnable);
			brownoutDetectOn   <= next_state
				!= reset_power_pkg::ST_TPD;
			comparatorsOn      <= next_state
				!= reset_power_pkg::ST_TPD;
			chipReset          <= anyReset;
			brownoutIntReq     <= brownoutIntEnable && brownoutDetectOn
				&& !supplyAboveTrip[intTripSel];
			flashProgramBlock  <= !pdState
				&& !supplyAboveFlashTrip;
			sharedPinInput     <= !reset_pin_enable
				&& !powerUpPhase;
			low_power_clock_select <= next_lowPower;
			reset_cause_reg    <= next_cause;
			bootPending        <= next_bootPending;
			bootAddress        <= next_bootAddress;
		end
	end

endmodule

`default_nettype wire

// ---- verification/reset_power_chk.sv ----
// Port assertions for the reset and power sequencer.
// Bound onto the sequencer from the testbench; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module reset_power_chk (
	input wire logic       clk_sys,                // Clock.
	input wire logic       rst_b,                  // Reset, low.
	input wire logic       modeEnter,              // Mode strobe.
	input wire logic [1:0] modeRequest,            // Mode asked.
	input wire logic [7:0] clock_divider_value,    // Divider.
	input wire logic       watchdogReset,          // Watchdog.
	input wire logic       cpuCoreClockTick,       // Core tick.
	input wire logic       coreClockRun,           // Core on.
	input wire logic       peripheralClockRun,     // Periph on.
	input wire logic       oscillatorRun,          // Osc on.
	input wire logic       brownoutDetectOn,       // Detect on.
	input wire logic       comparatorsOn,          // Comp on.
	input wire logic       chipReset,              // Core reset.
	input wire logic       flashProgramBlock,      // Flash block.
	input wire logic       low_power_clock_select, // LP select.
	input wire logic [5:0] reset_cause_reg         // Cause flags.
);
	// ------
	// Checks
	// ------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence entered(logic [1:0] r);
		modeEnter && modeRequest == r && coreClockRun && !chipReset;
	endsequence

	sequence flatRun;
		coreClockRun && clock_divider_value == 8'h00;
	endsequence

	chk_idle_entry: assert property (
		entered(reset_power_pkg::REQ_IDLE) |=> chipReset ||
		(!coreClockRun && peripheralClockRun))
		else $error("Idle entry wrong");
	chk_pd_entry: assert property (
		entered(reset_power_pkg::REQ_POWER_DOWN) |=> chipReset ||
		(!oscillatorRun && brownoutDetectOn && comparatorsOn))
		else $error("Power-down entry wrong");
	chk_tpd_entry: assert property (
		entered(reset_power_pkg::REQ_TOTAL_PD) |=> chipReset ||
		(!oscillatorRun && !brownoutDetectOn && !comparatorsOn))
		else $error("Total power-down entry wrong");
	chk_flash_pd: assert property (
		!oscillatorRun |-> !flashProgramBlock)
		else $error("Flash block in power-down");
	chk_wd_cause: assert property (
		watchdogReset |=> reset_cause_reg == reset_power_pkg::CAUSE_POWER_ON)
		else $error("Watchdog cause wrong");
	chk_lp_clear: assert property (
		$rose(chipReset) |-> ##[0:1] !low_power_clock_select)
		else $error("Low-power select kept");
	chk_div_zero: assert property (
		flatRun [*4] |-> cpuCoreClockTick)
		else $error("Undivided tick missing");
	chk_div_gap: assert property (
		cpuCoreClockTick && clock_divider_value == 8'h02 |=>
		(!cpuCoreClockTick || clock_divider_value != 8'h02) [*3])
		else $error("Divided tick too early");
endmodule
`default_nettype wire

// ---- verification/supply_pin_model.sv ----
// Far side: supply monitors and the external reset pin.
// The testbench sets the supply step and the pin drive.
`timescale 1ns/100ps
`default_nettype none
module supply_pin_model (
	input  wire logic [2:0] supplyLevel,     // Step, 4 is nominal.
	input  wire logic       pinLow,          // Pull pin low.
	output logic      [3:0] supplyAboveTrip, // Per trip level.
	output logic            shared_reset_pin // Pin level.
);
	// ------
	// Monitors
	// ------
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			supplyAboveTrip[k] = supplyLevel > 3'(k);
	end
	// A released pin rises to its pull-up.
	assign shared_reset_pin = !pinLow;
endmodule
`default_nettype wire

// ---- verification/tb_reset_power_sequencer.sv ----
// Self-checking bench for the reset and power sequencer.
// Needs the package, the design, its checker and the supply model.
`timescale 1ns/100ps
`default_nettype none
module tb_reset_power_sequencer;
	// ------
	// Signals
	// ------
	logic clk_sys, rst_b, lowPowerWrite, lowPowerData, modeEnter;
	logic idleWakeInt, powerDownWakeInt, rtcEnable, brownoutIntEnable;
	logic brownout_reset_trip_sel_hi, brownout_reset_trip_sel_lo;
	logic brownout_int_trip_sel_hi, brownout_int_trip_sel_lo;
	logic supplyAboveFlashTrip, powerOnDetect, shared_reset_pin;
	logic reset_pin_enable, watchdogReset, softwareReset, pinLow;
	logic uartBreakReset, causeWrite, bootStatusBit, in_system_programming;
	logic cpuCoreClockTick, coreClockRun, peripheralClockRun, chipReset;
	logic oscillatorRun, rcOscRun, brownoutDetectOn, comparatorsOn;
	logic brownoutIntReq, flashProgramBlock, sharedPinInput;
	logic low_power_clock_select;
	logic [1:0] clockSourceSel, modeRequest;
	logic [2:0] supplyLevel;
	logic [3:0] supplyAboveTrip;
	logic [5:0] causeWriteData, reset_cause_reg;
	logic [7:0] clock_divider_value, bootVector;
	logic [15:0] bootAddress;
	int n_errors, comparisons, n;

	reset_power_sequencer u_reset_power_sequencer (.*);
	supply_pin_model u_supply_pin_model (.*);

	always #20 clk_sys = ~clk_sys;

	// ------
	// Tasks
	// ------
	task automatic chk(input string s, input logic [15:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask

	task automatic waitRun;
		n = 0;
		while (coreClockRun !== 1'b1 && n < 8000)
		begin
			cyc(1);
			n++;
		end
	endtask

	task automatic wakeIs(input int w);
		waitRun;
		chk("wake", 1, n + 2 >= w && n <= w + 3);
	endtask

	task automatic pdWake(input int w);
		powerDownWakeInt = 1;
		cyc(1);
		powerDownWakeInt = 0;
		wakeIs(w);
	endtask

	// Sources: 0 pin, 1 software, 2 watchdog, 3 break.
	task automatic fire(input int k);
		{uartBreakReset, watchdogReset, softwareReset, pinLow} = 4'h1 << k;
		cyc(2);
		{uartBreakReset, watchdogReset, softwareReset, pinLow} = 4'h0;
		waitRun;
	endtask

	task automatic clearCause;
		causeWrite = 1;
		cyc(1);
		causeWrite = 0;
		cyc(1);
	endtask

	task automatic enter(input logic [1:0] r);
		modeRequest = r;
		modeEnter = 1;
		cyc(1);
		modeEnter = 0;
		cyc(2);
	endtask

	task automatic ticks(input logic [7:0] m, input int c, e);
		int t;
		t = 0;
		clock_divider_value = m;
		cyc(4);
		repeat (c)
		begin
			cyc(1);
			t += (cpuCoreClockTick === 1'b1);
		end
		chk("ticks", e, t);
		chk("run", 1, coreClockRun);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------
	// Tests
	// ------
	initial
	begin
		clk_sys = 0;
		rst_b = 0;
		clockSourceSel = reset_power_pkg::SRC_EXT;
		{clock_divider_value, modeRequest, causeWriteData} = '0;
		supplyLevel = 3'h4;
		bootVector = 8'hA5;
		{reset_pin_enable, supplyAboveFlashTrip} = 2'h3;
		{lowPowerWrite, lowPowerData, modeEnter, idleWakeInt, rtcEnable,
			powerDownWakeInt, brownoutIntEnable, powerOnDetect, pinLow,
			watchdogReset, softwareReset, uartBreakReset, causeWrite,
			bootStatusBit, in_system_programming, brownout_reset_trip_sel_hi,
			brownout_reset_trip_sel_lo, brownout_int_trip_sel_hi,
			brownout_int_trip_sel_lo} = '0;
		n_errors = 0;
		comparisons = 0;
		cyc(10);
		chk("cause", 6'h30, reset_cause_reg);
		rst_b = 1;
		wakeIs(32);
		chk("lp", 0, low_power_clock_select);
		chk("boot", 0, bootAddress);
		$display("test power-up done");
		clearCause;
		chk("cause", 6'h00, reset_cause_reg);
		fire(1);
		chk("cause", 6'h02, reset_cause_reg);
		fire(0);
		chk("cause", 6'h03, reset_cause_reg);
		fire(3);
		chk("cause", 6'h0B, reset_cause_reg);
		chk("boot", 16'hA500, bootAddress);
		fire(1);
		chk("boot", 0, bootAddress);
		bootStatusBit = 1;
		fire(1);
		chk("boot", 16'hA500, bootAddress);
		bootStatusBit = 0;
		{lowPowerWrite, lowPowerData} = 2'h3;
		cyc(1);
		lowPowerWrite = 0;
		cyc(1);
		chk("lp", 1, low_power_clock_select);
		fire(2);
		chk("cause", 6'h30, reset_cause_reg);
		chk("lp", 0, low_power_clock_select);
		{reset_pin_enable, pinLow} = 2'h1;
		cyc(3);
		chk("pinrst", 0, chipReset);
		chk("pinin", 1, sharedPinInput);
		in_system_programming = 1;
		rst_b = 0;
		cyc(2);
		rst_b = 1;
		cyc(3);
		chk("pupin", 1, chipReset);
		pinLow = 0;
		waitRun;
		chk("cause", 6'h31, reset_cause_reg);
		chk("boot", 16'hA500, bootAddress);
		in_system_programming = 0;
		fire(1);
		powerOnDetect = 1;
		cyc(2);
		powerOnDetect = 0;
		waitRun;
		chk("cause", 6'h30, reset_cause_reg);
		chk("boot", 0, bootAddress);
		$display("test reset causes done");
		ticks(8'h00, 20, 20);
		ticks(8'h02, 40, 10);
		ticks(8'hFF, 1020, 2);
		clock_divider_value = 8'h00;
		for (int s = 0; s < 4; s++)
		begin
			clearCause;
			{brownout_reset_trip_sel_hi, brownout_reset_trip_sel_lo} = 2'(s);
			supplyLevel = 3'(s + 1);
			cyc(3);
			chk("bor", 0, chipReset);
			supplyLevel = 3'(s);
			cyc(3);
			chk("bor", 1, chipReset);
			supplyLevel = 3'h4;
			waitRun;
			chk("bof", 1, reset_cause_reg[5]);
		end
		{brownout_reset_trip_sel_hi, brownout_reset_trip_sel_lo} = 2'h0;
		{brownout_int_trip_sel_hi, brownout_int_trip_sel_lo} = 2'h2;
		supplyLevel = 3'h2;
		cyc(3);
		chk("boi", 0, brownoutIntReq);
		brownoutIntEnable = 1;
		cyc(3);
		chk("boi", 1, brownoutIntReq);
		supplyLevel = 3'h4;
		cyc(3);
		chk("boi", 0, brownoutIntReq);
		{brownoutIntEnable, supplyAboveFlashTrip} = 2'h0;
		cyc(3);
		chk("flash", 1, flashProgramBlock);
		$display("test divider and brownout done");
		enter(2'h0);
		chk("noreq", 1, coreClockRun);
		enter(reset_power_pkg::REQ_IDLE);
		chk("idle", 2'h1, {coreClockRun, peripheralClockRun});
		idleWakeInt = 1;
		cyc(2);
		idleWakeInt = 0;
		chk("core", 1, coreClockRun);
		clockSourceSel = reset_power_pkg::SRC_RC;
		rtcEnable = 1;
		enter(reset_power_pkg::REQ_POWER_DOWN);
		chk("osc", 0, oscillatorRun);
		chk("pd", 4'h7, {flashProgramBlock, brownoutDetectOn,
			comparatorsOn, rcOscRun});
		pdWake(reset_power_pkg::RC_WAKE_CYC);
		rtcEnable = 0;
		enter(reset_power_pkg::REQ_TOTAL_PD);
		chk("tpd", 4'h0, {oscillatorRun, brownoutDetectOn,
			comparatorsOn, rcOscRun});
		supplyLevel = 3'h0;
		cyc(3);
		chk("tpdbor", 0, chipReset);
		supplyLevel = 3'h4;
		supplyAboveFlashTrip = 1;
		clockSourceSel = reset_power_pkg::SRC_CRYSTAL;
		pdWake(reset_power_pkg::XTAL_WAKE_CYC);
		$display("test power modes done");
		complete_run;
	end

	initial
	begin
		#(40 * 20000);
		n_errors++;
		complete_run;
	end
endmodule

bind reset_power_sequencer reset_power_chk u_reset_power_chk (.*);
`default_nettype wire
